// ==== pmc_pkg.sv ====
// package: command codes, reset values and carrier types for the command map
package pmc_pkg;

   // ----------------------------------------
   // command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_CURRENT_FAULT_STATUS   = 8'h7b;
   localparam logic [7:0] CMD_INPUT_FAULT_STATUS     = 8'h7c;
   localparam logic [7:0] CMD_EXTERNAL_TEMP_STATUS   = 8'h7d;
   localparam logic [7:0] CMD_COMM_MEMORY_STATUS     = 8'h7e;
   localparam logic [7:0] CMD_VENDOR_FAULT_STATE     = 8'h80;
   localparam logic [7:0] CMD_INPUT_VOLTAGE_READOUT  = 8'h88;
   localparam logic [7:0] CMD_OUTPUT_VOLTAGE_READOUT = 8'h8b;
   localparam logic [7:0] CMD_OUTPUT_CURRENT_READOUT = 8'h8c;
   localparam logic [7:0] CMD_EXTERNAL_TEMP_READOUT  = 8'h8d;
   localparam logic [7:0] CMD_DIE_TEMP_READOUT       = 8'h8e;
   localparam logic [7:0] CMD_OUTPUT_POWER_READOUT   = 8'h96;
   localparam logic [7:0] CMD_PROTOCOL_REVISION      = 8'h98;
   localparam logic [7:0] CMD_TOOL_RESERVED_WORD_A   = 8'hb0;
   localparam logic [7:0] CMD_TOOL_RESERVED_WORD_B   = 8'hb1;
   localparam logic [7:0] CMD_OEM_RESERVED_WORD      = 8'hb2;
   localparam logic [7:0] CMD_SCRATCH_WORD_PAGED     = 8'hb3;
   localparam logic [7:0] CMD_SCRATCH_WORD_GLOBAL    = 8'hb4;
   localparam logic [7:0] CMD_MAKER_RESERVED_A       = 8'hb5;
   localparam logic [7:0] CMD_MAKER_INFORMATION      = 8'hb6;
   localparam logic [7:0] CMD_SELF_HEATING_RISE      = 8'hb8;
   localparam logic [7:0] CMD_SELF_HEATING_INV_TAU   = 8'hb9;
   localparam logic [7:0] CMD_CORE_THERMAL_RESIST    = 8'hba;
   localparam logic [7:0] CMD_CURRENT_FIXED_READOUT  = 8'hbb;
   localparam logic [7:0] CMD_MAKER_RESERVED_B       = 8'hbc;
   localparam logic [7:0] CMD_NVM_UNLOCK             = 8'hbd;
   localparam logic [7:0] CMD_NVM_BULK_ERASE         = 8'hbe;
   localparam logic [7:0] CMD_NVM_STREAM_WORD        = 8'hbf;
   localparam logic [7:0] CMD_EXTRA_HOST_COMMAND     = 8'hc8;
   localparam logic [7:0] CMD_EXTRA_HOST_ZERO_WORD   = 8'hc9;
   localparam logic [7:0] CMD_EXTRA_HOST_ONE_WORD    = 8'hca;
   localparam logic [7:0] CMD_CHANNEL_CONFIGURATION  = 8'hd0;
   localparam logic [7:0] CMD_GLOBAL_CONFIGURATION   = 8'hd1;
   localparam logic [7:0] CMD_FAULT_LINE_A_PROPAGATE = 8'hd2;
   localparam logic [7:0] CMD_FAULT_LINE_B_PROPAGATE = 8'hd3;
   localparam logic [7:0] CMD_POWER_GOOD_MAPPING     = 8'hd4;
   localparam logic [7:0] CMD_FAULT_LINE_A_ACTION    = 8'hd5;
   localparam logic [7:0] CMD_FAULT_LINE_B_ACTION    = 8'hd6;

   // ----------------------------------------
   // reset values and constants
   // ----------------------------------------
   localparam logic [7:0]  PROTOCOL_REVISION_VALUE = 8'h11;
   localparam logic [15:0] FLOAT_ZERO_RESET        = 16'h8000;
   localparam logic [15:0] CHANNEL_CONFIG_RESET    = 16'h0080;
   localparam logic [15:0] GLOBAL_CONFIG_RESET     = 16'h0f7b;
   localparam logic [15:0] POWER_GOOD_MAP_RESET    = 16'h0000;
   localparam logic [15:0] SCRATCH_RESET           = 16'h0000;
   localparam logic [7:0]  BYTE_SETTING_RESET      = 8'h00;
   localparam logic [7:0]  NVM_UNLOCK_KEY          = 8'h2b;   // arbitrary unlock key value
   localparam logic [15:0] MAKER_INFO_VALUE        = 16'h0000; // arbitrary information value
   localparam logic [15:0] NVM_ERASED_WORD         = 16'hffff;
   localparam int          CURRENT_LSB_UA          = 2500;    // fixed-point current lsb, microamps

   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef struct packed {
      logic       wr;      // write strobe
      logic       rd;      // read strobe
      logic [7:0] code;    // command code
      logic [15:0] wdata;  // write data, byte in low bits
      logic [1:0] page;    // selected channel
   } pmc_req_t;

   typedef struct packed {
      logic        ack;    // request known and served
      logic        is_word;// two-byte command
      logic [15:0] rdata;
   } pmc_rsp_t;

endpackage

// ==== pmc_command_map.sv ====
// command-code register bank for a four-channel supply manager
`timescale 1ns/1ps
module pmc_command_map
   import pmc_pkg::*;
#(
   parameter int CHANNELS  = 4,
   parameter int NVM_WORDS = 64
) (
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  reset_n,
   // command port from the serial link engine
   input  wire pmc_req_t              req,
   output pmc_rsp_t                   rsp,
   // per-channel telemetry and status from the monitor
   input  wire logic [CHANNELS*8-1:0]  current_status_in,
   input  wire logic [CHANNELS*8-1:0]  temp_status_in,
   input  wire logic [CHANNELS*8-1:0]  vendor_status_in,
   input  wire logic [CHANNELS*16-1:0] vout_in,
   input  wire logic [CHANNELS*16-1:0] iout_float_in,
   input  wire logic [CHANNELS*16-1:0] iout_ua_in,
   input  wire logic [CHANNELS*16-1:0] ext_temp_in,
   input  wire logic [CHANNELS*16-1:0] pout_in,
   input  wire logic [CHANNELS*16-1:0] self_heat_in,
   // global telemetry and status
   input  wire logic [7:0]            input_status_in,
   input  wire logic [7:0]            comm_status_in,
   input  wire logic [15:0]           vin_in,
   input  wire logic [15:0]           die_temp_in,
   // settings and temperature out to the processing logic
   output logic [CHANNELS*16-1:0]      comp_temp,
   output logic [CHANNELS*16-1:0]      inv_tau,
   output logic [CHANNELS*16-1:0]      theta,
   output logic [CHANNELS*16-1:0]      chan_config,
   output logic [15:0]                global_config,
   output logic [CHANNELS-1:0]         fault_a_propagate,
   output logic [CHANNELS-1:0]         fault_b_propagate,
   output logic [15:0]                power_good_map,
   output logic [7:0]                 fault_a_action,
   output logic [7:0]                 fault_b_action,
   output logic [15:0]                extra_host_cmd,
   output logic                       nvm_unlocked
);

   // ----------------------------------------
   // parameter checks
   // ----------------------------------------
   if (CHANNELS != 4) begin : g_bad_ch
      $error("pmc_command_map: page field serves exactly four channels");
   end
   if (NVM_WORDS < 2 || NVM_WORDS > 256) begin : g_bad_nvm
      $error("pmc_command_map: NVM_WORDS must be 2..256");
   end

   localparam int AW = $clog2(NVM_WORDS);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [1:0] {
      NVM_LOCKED   = 2'b00,
      NVM_OPEN     = 2'b01,
      NVM_STREAM   = 2'b10
   } pmc_nvm_t;

   typedef struct packed {
      logic [3:0][15:0] scratch_paged;
      logic [3:0][15:0] tool_b;
      logic [3:0][15:0] rsvd_a;
      logic [3:0][15:0] rsvd_b;
      logic [3:0][15:0] inv_tau;
      logic [3:0][15:0] theta;
      logic [3:0][15:0] chan_cfg;
      logic [3:0][7:0]  prop_a;
      logic [3:0][7:0]  prop_b;
      logic [15:0]      tool_a;
      logic [15:0]      oem;
      logic [15:0]      scratch_global;
      logic [15:0]      glob_cfg;
      logic [15:0]      pg_map;
      logic [7:0]       act_a;
      logic [7:0]       act_b;
      logic [15:0]      xh_cmd;
      logic [15:0]      xh_data0;
      logic [15:0]      xh_data1;
      logic [7:0]       erase_byte;
      pmc_nvm_t         nvm;
      logic [AW-1:0]    nvm_ptr;
      pmc_rsp_t         rsp;
   } pmc_state_t;

   pmc_state_t st;
   pmc_state_t next_st;
   logic [15:0] nvm_mem [NVM_WORDS];
   logic        mem_wr;
   logic [15:0] mem_wdata;
   logic [AW-1:0] mem_addr;
   logic        erase_go;
   logic [AW:0] erase_cnt;

   // word of a flat per-channel bus
   function automatic logic [15:0] pick16(input logic [CHANNELS*16-1:0] v, input logic [1:0] p);
      pick16 = v[p*16 +: 16];
   endfunction

   function automatic logic [7:0] pick8(input logic [CHANNELS*8-1:0] v, input logic [1:0] p);
      pick8 = v[p*8 +: 8];
   endfunction

   // ----------------------------------------
   // next state: decode, writes and reads
   // ----------------------------------------
   always_comb begin
      logic [1:0] pg;
      pg = req.page;
      next_st = st;
      next_st.rsp = '0;
      mem_wr = 1'b0;
      mem_wdata = req.wdata;
      mem_addr = st.nvm_ptr;
      erase_go = 1'b0;
      next_st.rsp.ack = req.wr | req.rd;
      case (req.code)
         // byte-sized read-only status and revision
         CMD_CURRENT_FAULT_STATUS: next_st.rsp.rdata = {8'h00, pick8(current_status_in, pg)};
         CMD_INPUT_FAULT_STATUS:   next_st.rsp.rdata = {8'h00, input_status_in};
         CMD_EXTERNAL_TEMP_STATUS: next_st.rsp.rdata = {8'h00, pick8(temp_status_in, pg)};
         CMD_COMM_MEMORY_STATUS:   next_st.rsp.rdata = {8'h00, comm_status_in};
         CMD_VENDOR_FAULT_STATE:   next_st.rsp.rdata = {8'h00, pick8(vendor_status_in, pg)};
         CMD_PROTOCOL_REVISION:    next_st.rsp.rdata = {8'h00, PROTOCOL_REVISION_VALUE};
         // word-sized telemetry and maker information
         CMD_INPUT_VOLTAGE_READOUT: begin
            next_st.rsp.is_word = 1'b1;
            next_st.rsp.rdata = vin_in;
         end
         CMD_OUTPUT_VOLTAGE_READOUT: begin
            next_st.rsp.is_word = 1'b1;
            next_st.rsp.rdata = pick16(vout_in, pg);
         end
         CMD_OUTPUT_CURRENT_READOUT: begin
            next_st.rsp.is_word = 1'b1;
            next_st.rsp.rdata = pick16(iout_float_in, pg);
         end
         CMD_EXTERNAL_TEMP_READOUT: begin
            next_st.rsp.is_word = 1'b1;
            next_st.rsp.rdata = pick16(ext_temp_in, pg);
         end
         CMD_DIE_TEMP_READOUT: begin
            next_st.rsp.is_word = 1'b1;
            next_st.rsp.rdata = die_temp_in;
         end
         CMD_OUTPUT_POWER_READOUT: begin
            next_st.rsp.is_word = 1'b1;
            next_st.rsp.rdata = pick16(pout_in, pg);
         end
         CMD_SELF_HEATING_RISE: begin
            next_st.rsp.is_word = 1'b1;
            next_st.rsp.rdata = pick16(self_heat_in, pg);
         end
         CMD_CURRENT_FIXED_READOUT: begin
            next_st.rsp.is_word = 1'b1;
            next_st.rsp.rdata = 16'(pick16(iout_ua_in, pg) / 16'(CURRENT_LSB_UA / 100));
         end
         CMD_MAKER_INFORMATION: begin
            next_st.rsp.is_word = 1'b1;
            next_st.rsp.rdata = MAKER_INFO_VALUE;
         end
         // read/write words
         CMD_TOOL_RESERVED_WORD_A: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.tool_a = req.wdata;
            next_st.rsp.rdata = st.tool_a;
         end
         CMD_TOOL_RESERVED_WORD_B: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.tool_b[pg] = req.wdata;
            next_st.rsp.rdata = st.tool_b[pg];
         end
         CMD_OEM_RESERVED_WORD: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.oem = req.wdata;
            next_st.rsp.rdata = st.oem;
         end
         CMD_SCRATCH_WORD_PAGED: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.scratch_paged[pg] = req.wdata;
            next_st.rsp.rdata = st.scratch_paged[pg];
         end
         CMD_SCRATCH_WORD_GLOBAL: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.scratch_global = req.wdata;
            next_st.rsp.rdata = st.scratch_global;
         end
         CMD_MAKER_RESERVED_A: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.rsvd_a[pg] = req.wdata;
            next_st.rsp.rdata = st.rsvd_a[pg];
         end
         CMD_MAKER_RESERVED_B: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.rsvd_b[pg] = req.wdata;
            next_st.rsp.rdata = st.rsvd_b[pg];
         end
         CMD_SELF_HEATING_INV_TAU: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.inv_tau[pg] = req.wdata;
            next_st.rsp.rdata = st.inv_tau[pg];
         end
         CMD_CORE_THERMAL_RESIST: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.theta[pg] = req.wdata;
            next_st.rsp.rdata = st.theta[pg];
         end
         // nvm access
         CMD_NVM_UNLOCK: begin
            if (req.wr) begin
               next_st.nvm = (req.wdata[7:0] == NVM_UNLOCK_KEY) ? NVM_OPEN : NVM_LOCKED;
               next_st.nvm_ptr = '0;
            end
            next_st.rsp.rdata = {15'h0000, st.nvm != NVM_LOCKED};
         end
         CMD_NVM_BULK_ERASE: begin
            next_st.rsp.rdata = {8'h00, st.erase_byte};
            if (req.wr && st.nvm != NVM_LOCKED) begin
               next_st.erase_byte = req.wdata[7:0];
               next_st.nvm = NVM_STREAM;
               next_st.nvm_ptr = '0;
               erase_go = 1'b1;
            end
         end
         CMD_NVM_STREAM_WORD: begin
            next_st.rsp.is_word = 1'b1;
            if (st.nvm == NVM_LOCKED) begin
               next_st.rsp.ack = 1'b0;
            end else begin
               next_st.rsp.rdata = nvm_mem[st.nvm_ptr];
               mem_wr = req.wr;
               if (req.wr || req.rd) next_st.nvm_ptr = AW'(st.nvm_ptr + 1'b1);
            end
         end
         // extra hosts
         CMD_EXTRA_HOST_COMMAND: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.xh_cmd = req.wdata;
            next_st.rsp.rdata = st.xh_cmd;
         end
         CMD_EXTRA_HOST_ZERO_WORD: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.xh_data0 = req.wdata;
            next_st.rsp.rdata = st.xh_data0;
         end
         CMD_EXTRA_HOST_ONE_WORD: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.xh_data1 = req.wdata;
            next_st.rsp.rdata = st.xh_data1;
         end
         // configuration
         CMD_CHANNEL_CONFIGURATION: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.chan_cfg[pg] = req.wdata;
            next_st.rsp.rdata = st.chan_cfg[pg];
         end
         CMD_GLOBAL_CONFIGURATION: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.glob_cfg = req.wdata;
            next_st.rsp.rdata = st.glob_cfg;
         end
         CMD_FAULT_LINE_A_PROPAGATE: begin
            if (req.wr) next_st.prop_a[pg] = req.wdata[7:0];
            next_st.rsp.rdata = {8'h00, st.prop_a[pg]};
         end
         CMD_FAULT_LINE_B_PROPAGATE: begin
            if (req.wr) next_st.prop_b[pg] = req.wdata[7:0];
            next_st.rsp.rdata = {8'h00, st.prop_b[pg]};
         end
         CMD_POWER_GOOD_MAPPING: begin
            next_st.rsp.is_word = 1'b1;
            if (req.wr) next_st.pg_map = req.wdata;
            next_st.rsp.rdata = st.pg_map;
         end
         CMD_FAULT_LINE_A_ACTION: begin
            if (req.wr) next_st.act_a = req.wdata[7:0];
            next_st.rsp.rdata = {8'h00, st.act_a};
         end
         CMD_FAULT_LINE_B_ACTION: begin
            if (req.wr) next_st.act_b = req.wdata[7:0];
            next_st.rsp.rdata = {8'h00, st.act_b};
         end
         default: begin
            next_st.rsp.ack = 1'b0;   // unknown code: no acknowledge
         end
      endcase
      // read-only status and revision bytes refuse writes
      if (req.wr && (req.code == CMD_CURRENT_FAULT_STATUS || req.code == CMD_INPUT_FAULT_STATUS ||
                     req.code == CMD_EXTERNAL_TEMP_STATUS || req.code == CMD_COMM_MEMORY_STATUS ||
                     req.code == CMD_VENDOR_FAULT_STATE || req.code == CMD_PROTOCOL_REVISION)) begin
         next_st.rsp.ack = 1'b0;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
         st.inv_tau  <= {4{FLOAT_ZERO_RESET}};
         st.theta    <= {4{FLOAT_ZERO_RESET}};
         st.chan_cfg <= {4{CHANNEL_CONFIG_RESET}};
         st.glob_cfg <= GLOBAL_CONFIG_RESET;
         st.pg_map   <= POWER_GOOD_MAP_RESET;
         st.scratch_paged  <= {4{SCRATCH_RESET}};
         st.scratch_global <= SCRATCH_RESET;
         st.prop_a <= {4{BYTE_SETTING_RESET}};
         st.prop_b <= {4{BYTE_SETTING_RESET}};
         st.act_a  <= BYTE_SETTING_RESET;
         st.act_b  <= BYTE_SETTING_RESET;
         st.nvm    <= NVM_LOCKED;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // user nvm array: erase sweep and stream writes
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         erase_cnt <= '0;
      end else if (erase_go) begin
         erase_cnt <= (AW+1)'(NVM_WORDS);
      end else if (erase_cnt != '0) begin
         erase_cnt <= erase_cnt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (erase_cnt != '0) begin
         nvm_mem[AW'(erase_cnt - 1'b1)] <= NVM_ERASED_WORD;
      end else if (mem_wr) begin
         nvm_mem[mem_addr] <= mem_wdata;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign rsp            = st.rsp;
   assign comp_temp      = ext_temp_in;
   assign inv_tau        = st.inv_tau;
   assign theta          = st.theta;
   assign chan_config    = st.chan_cfg;
   assign global_config  = st.glob_cfg;
   assign power_good_map = st.pg_map;
   assign fault_a_action = st.act_a;
   assign fault_b_action = st.act_b;
   assign extra_host_cmd = st.xh_cmd;
   assign nvm_unlocked   = (st.nvm != NVM_LOCKED);

   // propagation enable is the low bit of each channel byte
   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         fault_a_propagate[c] = st.prop_a[c][0];
         fault_b_propagate[c] = st.prop_b[c][0];
      end
   end

endmodule

// ==== pmc_command_map_checker.sv ====
// assertion checker for the command map ports
`timescale 1ns/1ps
module pmc_command_map_checker
   import pmc_pkg::*;
#(
   parameter int CHANNELS  = 4,
   parameter int NVM_WORDS = 64
) (
   // clock and reset
   input wire logic                   sys_clk,
   input wire logic                   reset_n,
   // command port
   input wire pmc_req_t               req,
   input wire pmc_rsp_t               rsp,
   // telemetry in
   input wire logic [CHANNELS*16-1:0] iout_ua_in,
   input wire logic [CHANNELS*16-1:0] ext_temp_in,
   input wire logic [7:0]             input_status_in,
   input wire logic [7:0]             comm_status_in,
   // settings out
   input wire logic [CHANNELS*16-1:0] comp_temp,
   input wire logic [15:0]            global_config,
   input wire logic [15:0]            power_good_map,
   input wire logic                   nvm_unlocked
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // fixed-point current of the addressed channel, 100 uA units to 2.5 mA units
   logic [15:0] fix_exp;
   always_ff @(posedge sys_clk) fix_exp <= iout_ua_in[req.page*16 +: 16] / 16'd25;
   // ----
   // assertions
   // ----
   a_ack_has_cause: assert property (rsp.ack |-> $past(req.rd) || $past(req.wr))
      else $error("answer without a request");
   a_revision_const: assert property (req.rd && req.code == 8'h98 |=> rsp.ack && !rsp.is_word && rsp.rdata == 16'h0011)
      else $error("revision read wrong");
   a_fixed_current: assert property (req.rd && req.code == 8'hbb |=> rsp.ack && rsp.rdata == fix_exp)
      else $error("fixed current readout wrong");
   a_temp_source: assert property (comp_temp == ext_temp_in)
      else $error("processing temperature not external reading");
   a_locked_refuse: assert property ((req.rd || req.wr) && req.code == 8'hbf && !nvm_unlocked |=> !rsp.ack)
      else $error("stream served while locked");
   a_unlock_cause: assert property ($rose(nvm_unlocked) |-> $past(req.wr) && $past(req.code) == 8'hbd)
      else $error("unlock without unlock write");
   a_global_write: assert property (req.wr && req.code == 8'hd1 |=> global_config == $past(req.wdata) && rsp.is_word)
      else $error("global config write lost");
   a_pgood_write: assert property (req.wr && req.code == 8'hd4 |=> power_good_map == $past(req.wdata))
      else $error("power good map write lost");
   a_input_status: assert property (req.rd && req.code == 8'h7c |=> rsp.rdata == {8'h00, $past(input_status_in)})
      else $error("input status read wrong");
   a_comm_status: assert property (req.rd && req.code == 8'h7e |=> rsp.rdata == {8'h00, $past(comm_status_in)})
      else $error("comm status read wrong");
endmodule

bind pmc_command_map pmc_command_map_checker #(.CHANNELS(CHANNELS), .NVM_WORDS(NVM_WORDS)) u_chk (
   .sys_clk, .reset_n, .req, .rsp, .iout_ua_in, .ext_temp_in, .input_status_in,
   .comm_status_in, .comp_temp, .global_config, .power_good_map, .nvm_unlocked);

// ==== pmc_host_model.sv ====
// host controller model issuing command transfers
`timescale 1ns/1ps
module pmc_host_model
   import pmc_pkg::*;
(
   // clock
   input  wire logic     sys_clk,
   // command port
   output pmc_req_t      req,
   input  wire pmc_rsp_t rsp
);
   initial req = '0;
   // one transfer: driven after an edge, taken and answered at the next; release drops the strobes and inverts code, data and page
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                       input logic [1:0] page, output pmc_rsp_t r);
      @(posedge sys_clk);
      req <= '{wr, !wr, code, data, page};
      @(posedge sys_clk);
      req <= '{1'b0, 1'b0, ~code, ~data, ~page};
      #1 r = rsp;
   endtask
   // unlock, erase, then wait out the erase sweep before streaming
   task automatic nvm_open(input int sweep);
      pmc_rsp_t r;
      xfer(1'b1, 8'hbd, 16'h002b, 2'h0, r);
      xfer(1'b1, 8'hbe, 16'h0001, 2'h0, r);
      repeat (sweep + 1) @(posedge sys_clk);
   endtask
endmodule

// ==== pmc_command_map_bench.sv ====
// self-checking bench for the command map
`timescale 1ns/1ps
module pmc_command_map_bench import pmc_pkg::*;;
   // ----
   // signals and table
   // ----
   typedef struct packed {
      logic        wr;
      logic [7:0]  code;
      logic [15:0] data;
      logic [1:0]  page;
      logic        ack;
      logic        word;
      logic [15:0] exp;
   } pmc_row_t;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   pmc_req_t    req;
   pmc_rsp_t    rsp, r;
   logic [17:0] e;
   logic [63:0] tau, ccfg, th, ctmp;
   logic [15:0] gcfg, pgm, ehc;
   logic [3:0]  fpa, fpb;
   logic [7:0]  facta, factb;
   // telemetry and status levels fed to the device
   logic [31:0] cst = 32'h0403_0201, tst = 32'h0807_0605, vst = 32'h0c0b_0a09;
   logic [63:0] vo = 64'h4444_3333_2222_1111, ifl = 64'h8888_7777_6666_5555;
   logic [63:0] etp = 64'hdddd_bbbb_9999_7777, pw = 64'hd4d4_c3c3_b2b2_a1a1;
   logic [63:0] sh = 64'h0404_0303_0202_0101;
   logic [7:0]  ist = 8'h3c, cms = 8'hc3;
   logic [15:0] vi = 16'h5a5a, dt = 16'ha5a5;
   logic        unl;
   int          miscompares = 0;
   int          tests_run = 0;
   // channel 3 carries 2500 x 100 uA = 250 mA, i.e. 100 steps of 2.5 mA
   logic [63:0] iua = 64'h09c4_0000_0000_0000;
   pmc_row_t rows[$] = '{
      '{0,8'hd0,16'h0,2,1,1,16'h0080}, '{0,8'hd1,16'h0,0,1,1,16'h0f7b},
      '{0,8'hd2,16'h0,1,1,0,16'h0000}, '{0,8'hd3,16'h0,3,1,0,16'h0000},
      '{0,8'hd4,16'h0,0,1,1,16'h0000}, '{0,8'hd5,16'h0,0,1,0,16'h0000},
      '{0,8'hd6,16'h0,0,1,0,16'h0000}, '{0,8'hb9,16'h0,0,1,1,16'h8000},
      '{0,8'hba,16'h0,3,1,1,16'h8000}, '{0,8'hb3,16'h0,1,1,1,16'h0000},
      '{0,8'h98,16'h0,0,1,0,16'h0011}, '{0,8'h7b,16'h0,1,1,0,16'h0002},
      '{0,8'h7c,16'h0,2,1,0,16'h003c}, '{0,8'h7e,16'h0,3,1,0,16'h00c3},
      '{0,8'h88,16'h0,1,1,1,16'h5a5a}, '{0,8'h8b,16'h0,0,1,1,16'h1111},
      '{0,8'h7d,16'h0,0,1,0,16'h0005}, '{0,8'h80,16'h0,3,1,0,16'h000c},
      '{0,8'h8c,16'h0,2,1,1,16'h7777}, '{0,8'h8e,16'h0,1,1,1,16'ha5a5},
      '{0,8'h8d,16'h0,2,1,1,16'hbbbb}, '{0,8'hb8,16'h0,1,1,1,16'h0202},
      '{0,8'hbb,16'h0,3,1,1,16'h0064}, '{1,8'h96,16'h0,3,1,1,16'h0000},
      '{0,8'h96,16'h0,3,1,1,16'hd4d4}, '{1,8'hd1,16'h1234,0,1,1,16'h0},
      '{0,8'hd1,16'h0,2,1,1,16'h1234}, '{1,8'hd0,16'habcd,1,1,1,16'h0},
      '{0,8'hd0,16'h0,0,1,1,16'h0080}, '{0,8'hd0,16'h0,1,1,1,16'habcd},
      '{1,8'hd2,16'h0001,2,1,0,16'h0}, '{1,8'hd3,16'h0001,3,1,0,16'h0},
      '{1,8'hd4,16'h000f,0,1,1,16'h0}, '{1,8'hd5,16'h00a5,0,1,0,16'h0},
      '{1,8'hd6,16'h005a,0,1,0,16'h0}, '{0,8'hd6,16'h0,0,1,0,16'h005a},
      '{1,8'h98,16'h0022,0,0,0,16'h0}, '{0,8'hb7,16'h0,0,0,0,16'h0000},
      '{1,8'hc9,16'hbeef,0,1,1,16'h0}, '{1,8'hca,16'h0bad,0,1,1,16'h0},
      '{0,8'hc9,16'h0,0,1,1,16'hbeef}, '{0,8'hca,16'h0,0,1,1,16'h0bad}
   };
   // clock
   always #10 sys_clk = ~sys_clk;
   // ----
   // device and host
   // ----
   pmc_command_map #(.NVM_WORDS(4)) uut (
      .sys_clk, .reset_n, .req, .rsp,
      .current_status_in(cst), .temp_status_in(tst), .vendor_status_in(vst),
      .vout_in(vo), .iout_float_in(ifl), .iout_ua_in(iua),
      .ext_temp_in(etp), .pout_in(pw),
      .self_heat_in(sh), .input_status_in(ist), .comm_status_in(cms),
      .vin_in(vi), .die_temp_in(dt), .comp_temp(ctmp), .inv_tau(tau), .theta(th),
      .chan_config(ccfg), .global_config(gcfg), .fault_a_propagate(fpa), .fault_b_propagate(fpb),
      .power_good_map(pgm), .fault_a_action(facta), .fault_b_action(factb), .extra_host_cmd(ehc),
      .nvm_unlocked(unl));
   pmc_host_model host (.sys_clk, .req, .rsp);
   // compare and count
   task automatic chk(input string n, input logic [17:0] x, input logic [17:0] s);
      tests_run++;
      if (s !== x) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask
   // verdict and end of run
   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // watchdog cuts a hang short
   initial begin
      repeat (5000) @(posedge sys_clk);
      miscompares++;
      $display("ERROR watchdog expected finish seen hang");
      conclude();
   end
   // ----
   // tests
   // ----
   initial begin
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      foreach (rows[i]) begin
         host.xfer(rows[i].wr, rows[i].code, rows[i].data, rows[i].page, r);
         e = {rows[i].ack, rows[i].word, rows[i].exp};
         if (!rows[i].ack) e[16:0] = {r.is_word, r.rdata};
         else if (rows[i].wr) e[15:0] = r.rdata;
         chk($sformatf("row %0d", i), e, {r.ack, r.is_word, r.rdata});
      end
      // settings reach their outputs
      chk("prop_a", 18'h4, {14'h0, fpa});
      chk("prop_b", 18'h8, {14'h0, fpb});
      chk("act_a", 18'h00a5, {10'h0, facta});
      chk("act_b", 18'h005a, {10'h0, factb});
      chk("pgm", 18'h000f, {2'h0, pgm});
      chk("theta", 18'h8000, {2'h0, th[63:48]});
      // a new external reading reaches both the readout and the processing output
      @(posedge sys_clk);
      etp <= 64'h0123_4567_89ab_cdef;
      host.xfer(1'b0, 8'h8d, 16'h0, 2'h1, r);
      chk("temp", {2'h3, 16'h89ab}, {r.ack, r.is_word, r.rdata});
      chk("comp", 18'h0cdef, {2'h0, ctmp[15:0]});
      host.xfer(1'b1, 8'hc8, 16'h00c9, 2'h0, r);
      chk("xcmd", 18'h00c9, {2'h0, ehc});
      // stream refused while locked, then written and read back with wrap
      host.xfer(1'b1, 8'hbf, 16'h1111, 2'h0, r);
      chk("locked", 18'h0, {17'h0, r.ack});
      host.nvm_open(4);
      chk("unlock", 18'h1, {17'h0, unl});
      for (int k = 0; k < 8; k++) begin
         host.xfer(k < 4, 8'hbf, 16'ha000 + 16'(k), 2'h0, r);
         if (k >= 4) chk("stream", {2'h3, 16'ha000 + 16'(k - 4)}, {r.ack, r.is_word, r.rdata});
      end
      host.nvm_open(4);
      host.xfer(1'b0, 8'hbf, 16'h0, 2'h0, r);
      chk("erased", 18'h3ffff, {r.ack, r.is_word, r.rdata});
      host.xfer(1'b1, 8'hbd, 16'h0000, 2'h0, r);
      host.xfer(1'b0, 8'hbf, 16'h0, 2'h0, r);
      chk("relock", 18'h0, {16'h0, unl, r.ack});
      // reset in mid-run restores the defaults
      @(posedge sys_clk);
      reset_n <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("gcfg", 18'h0f7b, {2'h0, gcfg});
      chk("ccfg", 18'h0080, {2'h0, ccfg[31:16]});
      chk("tau", 18'h8000, {2'h0, tau[31:16]});
      chk("rst", 18'h0, {2'h0, fpa, fpb, facta});
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      host.xfer(1'b0, 8'hd4, 16'h0, 2'h0, r);
      chk("pgood", 18'h30000, {r.ack, r.is_word, r.rdata});
      conclude();
   end
endmodule
